// file: core/ioc_osc_ctrl.v
// Purpose: Control of the slow, ultra-low-power and mid-frequency internal oscillators
// Assumes: Oscillator clocks arrive as pins and are sampled on clock; Avalon-MM slave
// Notes: Oscillator enables are levels to the analog cells; all outputs are registered
//
// Operation
// - Start-up code 0..7 selects counter length 3,4,6,10,18,34,66,130 cycles.
// - Start-up counter counts ultra-low-power oscillator cycles, not the started oscillator.
// - Synchronisation delay follows the count before the slow ready flag rises.
// - Total start-up equals counter length plus two slow oscillator cycles.
// - On-demand set: oscillator runs only while a peripheral requests it.
// - On-demand clear: enabled oscillator runs continuously regardless of requests.
// - In standby, gating stays only with run-in-standby set; else oscillator off.
// - Run-in-standby set: keeps running in standby, gated by on-demand as usual.
// - Slow oscillator output enable at bit 2 drives the 32 kHz output.
// - Slow oscillator enable at bit 1 turns the oscillator on.
// - Write-lock bit 7 freezes the ultra-low-power control register.
// - Ultra-low-power trim at bits 4:0 loads from flash calibration at start-up.
// - Mid-frequency band at bits 31:30 loads from flash; four frequency bands.
// - Mid-frequency trim at bits 27:16 loads from flash; upper six bits temperature.
// - Lower six trim bits are the overall process trim.
// - Mid control resets enabled, on-demand, no standby, divider 3; write-protected.
// - Divider codes 0..3 divide the mid-frequency output by 1,2,4,8.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "ioc_defs.vh"

module ioc_osc_ctrl #(
  parameter ULP_CAL_W = 5,
  parameter MID_CAL_W = 12,
  parameter SLOW_CAL_W = 7
) (
  input wire clock,
  input wire reset_n,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg irq,
  input wire standby,
  input wire slow_request,
  input wire mid_request,
  input wire ulp_osc_clk,
  input wire slow_osc_clk,
  input wire mid_osc_clk,
  input wire [ULP_CAL_W-1:0] flash_ulp_trim,
  input wire [MID_CAL_W-1:0] flash_mid_trim,
  input wire [1:0] flash_mid_band,
  input wire [SLOW_CAL_W-1:0] flash_slow_trim,
  output reg slow_osc_run,
  output reg slow_clock_out,
  output reg [SLOW_CAL_W-1:0] slow_trim,
  output reg ulp_osc_run,
  output reg [ULP_CAL_W-1:0] ulp_trim,
  output reg mid_osc_run,
  output reg [1:0] mid_band,
  output reg [MID_CAL_W-1:0] mid_trim,
  output reg mid_clock_out
);

  localparam ST_IDLE = 2'h0;
  localparam ST_COUNT = 2'h1;
  localparam ST_SYNC = 2'h2;
  localparam ST_READY = 2'h3;

  // Reset release through two flops
  reg rst_s1_r;
  reg rst_n_r;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Two-flop synchronisers for all pin inputs
  reg [6:0] pin_s1_r;
  reg [6:0] pin_s2_r;
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
    end else begin
      pin_s1_r <= {standby, slow_request, mid_request, ulp_osc_clk, slow_osc_clk, mid_osc_clk, 1'b0};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire stby_s = pin_s2_r[6];
  wire slow_req_s = pin_s2_r[5];
  wire mid_req_s = pin_s2_r[4];

  // Edge detectors read only second-stage copies
  reg [2:0] clk_d_r;
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_d_r <= 3'h0;
    end else begin
      clk_d_r <= pin_s2_r[3:1];
    end
  end
  wire ulp_tick = pin_s2_r[3] & ~clk_d_r[2];
  wire slow_tick = pin_s2_r[2] & ~clk_d_r[1];
  wire mid_tick = pin_s2_r[1] & ~clk_d_r[0];

  // Control registers
  reg [31:0] slow_ctrl_r;
  reg [7:0] ulp_ctrl_r;
  reg [31:0] mid_ctrl_r;
  reg [1:0] status_r;
  reg [1:0] mask_r;
  reg wp_open_r;
  reg cal_load_r;

  // Flash trim is caught by a clocked load after reset release, never by the reset itself
  // Writes land at the answer edge, where the master sees waitrequest low
  wire is_wr = write & ~waitrequest;
  wire wr_slow = is_wr & (address == `IOC_OFS_SLOW_CTRL) & wp_open_r & ~slow_ctrl_r[`IOC_SLOW_LOCK_BIT];
  wire wr_ulp = is_wr & (address == `IOC_OFS_ULP_CTRL) & wp_open_r & ~ulp_ctrl_r[`IOC_ULP_LOCK_BIT];
  wire wr_mid = is_wr & (address == `IOC_OFS_MID_CTRL) & wp_open_r;
  wire wr_stat = is_wr & (address == `IOC_OFS_STATUS);
  wire wr_mask = is_wr & (address == `IOC_OFS_IRQ_MASK);
  wire wr_wp = is_wr & (address == `IOC_OFS_WPROT);

  // Byte-lane merge
  function [31:0] ioc_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      ioc_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          ioc_merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      slow_ctrl_r <= `IOC_SLOW_RESET;
      ulp_ctrl_r <= 8'h00;
      mid_ctrl_r <= {16'h0000, `IOC_MID_RESET_LOW};
      mask_r <= 2'h0;
      wp_open_r <= 1'b0;
      cal_load_r <= 1'b1;
    end else begin
      cal_load_r <= 1'b0;
      if (cal_load_r) begin
        ulp_ctrl_r[`IOC_ULP_CAL_LO +: ULP_CAL_W] <= flash_ulp_trim;
        mid_ctrl_r[`IOC_MID_BAND_LO +: 2] <= flash_mid_band;
        mid_ctrl_r[`IOC_MID_CAL_LO +: MID_CAL_W] <= flash_mid_trim;
        slow_ctrl_r[`IOC_SLOW_CAL_LO +: SLOW_CAL_W] <= flash_slow_trim;
      end else begin
        if (wr_slow) slow_ctrl_r <= ioc_merge(slow_ctrl_r, writedata, byteenable) & 32'h007f17c6;
        if (wr_ulp && byteenable[0]) ulp_ctrl_r <= writedata[7:0] & 8'h9f;
        if (wr_mid) mid_ctrl_r <= ioc_merge(mid_ctrl_r, writedata, byteenable) & 32'hcfff03c2;
      end
      if (wr_mask && byteenable[0]) mask_r <= writedata[1:0];
      if (wr_wp) wp_open_r <= (writedata == `IOC_WPROT_KEY);
    end
  end

  // Slow oscillator run request, shared gating for both gated oscillators
  wire slow_want = slow_ctrl_r[`IOC_SLOW_EN_BIT]
    & (~stby_s | slow_ctrl_r[`IOC_SLOW_STBY_BIT])
    & (~slow_ctrl_r[`IOC_SLOW_ODM_BIT] | slow_req_s);
  wire mid_want = mid_ctrl_r[`IOC_MID_EN_BIT]
    & (~stby_s | mid_ctrl_r[`IOC_MID_STBY_BIT])
    & (~mid_ctrl_r[`IOC_MID_ODM_BIT] | mid_req_s);

  // Start-up length lookup
  reg [7:0] su_len;
  always @* begin
    case (slow_ctrl_r[`IOC_SLOW_SU_LO +: 3])
      3'h0: su_len = 8'h03;
      3'h1: su_len = 8'h04;
      3'h2: su_len = 8'h06;
      3'h3: su_len = 8'h0a;
      3'h4: su_len = 8'h12;
      3'h5: su_len = 8'h22;
      3'h6: su_len = 8'h42;
      default: su_len = 8'h82;
    endcase
  end

  // Slow start-up sequencer; count then sync, restarted whenever the oscillator stops
  reg [1:0] su_state_r;
  reg [7:0] su_cnt_r;
  reg [1:0] sync_cnt_r;
  reg slow_rdy_set;
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      su_state_r <= ST_IDLE;
      su_cnt_r <= 8'h00;
      sync_cnt_r <= 2'h0;
    end else if (!slow_want) begin
      su_state_r <= ST_IDLE;
    end else begin
      case (su_state_r)
        ST_IDLE: begin
          su_state_r <= ST_COUNT;
          su_cnt_r <= su_len;
        end
        ST_COUNT: begin
          if (ulp_tick) begin
            if (su_cnt_r == 8'h01) begin
              su_state_r <= ST_SYNC;
              sync_cnt_r <= 2'h0;
            end else begin
              su_cnt_r <= su_cnt_r - 8'h01;
            end
          end
        end
        ST_SYNC: begin
          if (slow_tick) begin
            if (sync_cnt_r == `IOC_SYNC_CYCLES - 1) su_state_r <= ST_READY;
            sync_cnt_r <= sync_cnt_r + 2'h1;
          end
        end
        ST_READY: su_state_r <= ST_READY;
        default: su_state_r <= ST_IDLE;
      endcase
    end
  end
  always @* begin
    slow_rdy_set = slow_want & (su_state_r == ST_SYNC) & slow_tick & (sync_cnt_r == `IOC_SYNC_CYCLES - 1);
  end

  // Mid oscillator ready after its first edge while running
  reg mid_seen_r;
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mid_seen_r <= 1'b0;
    end else begin
      mid_seen_r <= mid_want & (mid_seen_r | mid_tick);
    end
  end
  wire mid_rdy_set = mid_want & ~mid_seen_r & mid_tick;

  // Sticky status, write one to clear; a new event wins over the clear
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_r <= 2'h0;
    end else begin
      status_r[`IOC_ST_SLOW_RDY] <= slow_rdy_set |
        (status_r[`IOC_ST_SLOW_RDY] & ~(wr_stat & byteenable[0] & writedata[`IOC_ST_SLOW_RDY]));
      status_r[`IOC_ST_MID_RDY] <= mid_rdy_set |
        (status_r[`IOC_ST_MID_RDY] & ~(wr_stat & byteenable[0] & writedata[`IOC_ST_MID_RDY]));
    end
  end

  // Mid output divider: toggles every 2^(code-1) mid edges
  reg [2:0] div_cnt_r;
  wire [1:0] div_code = mid_ctrl_r[`IOC_MID_DIV_LO +: 2];
  wire [2:0] div_mask = (3'h1 << div_code) - 3'h1;
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_cnt_r <= 3'h0;
      mid_clock_out <= 1'b0;
    end else if (!mid_want) begin
      div_cnt_r <= 3'h0;
      mid_clock_out <= 1'b0;
    end else if (div_code == 2'h0) begin
      mid_clock_out <= pin_s2_r[1];
    end else if (mid_tick) begin
      div_cnt_r <= (div_cnt_r + 3'h1) & (div_mask >> 1);
      if ((div_cnt_r & (div_mask >> 1)) == (div_mask >> 1)) mid_clock_out <= ~mid_clock_out;
    end
  end

  // Registered oscillator-facing outputs
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      slow_osc_run <= 1'b0;
      slow_clock_out <= 1'b0;
      slow_trim <= {SLOW_CAL_W{1'b0}};
      ulp_osc_run <= 1'b0;
      ulp_trim <= {ULP_CAL_W{1'b0}};
      mid_osc_run <= 1'b0;
      mid_band <= 2'h0;
      mid_trim <= {MID_CAL_W{1'b0}};
      irq <= 1'b0;
    end else begin
      slow_osc_run <= slow_want;
      slow_clock_out <= slow_ctrl_r[`IOC_SLOW_OUT_BIT] & (su_state_r == ST_READY) & pin_s2_r[2];
      slow_trim <= slow_ctrl_r[`IOC_SLOW_CAL_LO +: SLOW_CAL_W];
      ulp_osc_run <= 1'b1;
      ulp_trim <= ulp_ctrl_r[`IOC_ULP_CAL_LO +: ULP_CAL_W];
      mid_osc_run <= mid_want;
      mid_band <= mid_ctrl_r[`IOC_MID_BAND_LO +: 2];
      mid_trim <= mid_ctrl_r[`IOC_MID_CAL_LO +: MID_CAL_W];
      irq <= |(status_r & mask_r);
    end
  end

  // Avalon slave: one wait cycle, answer at second edge; unmapped reads give zero
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read && waitrequest) begin
        case (address)
          `IOC_OFS_SLOW_CTRL: readdata <= slow_ctrl_r;
          `IOC_OFS_ULP_CTRL: readdata <= {24'h000000, ulp_ctrl_r};
          `IOC_OFS_MID_CTRL: readdata <= mid_ctrl_r;
          `IOC_OFS_STATUS: readdata <= {30'h00000000, status_r};
          `IOC_OFS_IRQ_MASK: readdata <= {30'h00000000, mask_r};
          `IOC_OFS_WPROT: readdata <= {31'h00000000, wp_open_r};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // ioc_osc_ctrl

// file: shared/ioc_defs.vh
// Purpose: Register map, field positions, reset values and timing counts for the oscillator control block
// Assumes: 32-bit Avalon-MM word access, byte addresses
// Notes: Definitions only
`ifndef IOC_DEFS_VH
`define IOC_DEFS_VH

// Register byte offsets
`define IOC_OFS_SLOW_CTRL 6'h18
`define IOC_OFS_ULP_CTRL 6'h1c
`define IOC_OFS_MID_CTRL 6'h20
`define IOC_OFS_STATUS 6'h24
`define IOC_OFS_IRQ_MASK 6'h28
`define IOC_OFS_WPROT 6'h2c

// Slow internal oscillator control fields
`define IOC_SLOW_EN_BIT 1
`define IOC_SLOW_OUT_BIT 2
`define IOC_SLOW_STBY_BIT 6
`define IOC_SLOW_ODM_BIT 7
`define IOC_SLOW_SU_LO 8
`define IOC_SLOW_LOCK_BIT 12
`define IOC_SLOW_CAL_LO 16
`define IOC_SLOW_RESET 32'h003f0080

// Ultra-low-power oscillator control fields
`define IOC_ULP_LOCK_BIT 7
`define IOC_ULP_CAL_LO 0

// Mid-frequency oscillator control fields
`define IOC_MID_EN_BIT 1
`define IOC_MID_STBY_BIT 6
`define IOC_MID_ODM_BIT 7
`define IOC_MID_DIV_LO 8
`define IOC_MID_CAL_LO 16
`define IOC_MID_BAND_LO 30
`define IOC_MID_RESET_LOW 16'h0382

// Status bits
`define IOC_ST_SLOW_RDY 0
`define IOC_ST_MID_RDY 1

// Write-protect unlock key
`define IOC_WPROT_KEY 32'h0000a5c3

// Extra slow-osc cycles after the start-up count
`define IOC_SYNC_CYCLES 2

`endif

// file: bench/ioc_osc_ctrl_chk.sv
// Purpose: Port assertions for the oscillator control block
// Assumes: Bound to ioc_osc_ctrl, one clock domain
// Notes: Trims may move only shortly after a bus write
`timescale 1ns/1ps
module ioc_osc_ctrl_chk #(
  parameter ULP_CAL_W = 5,
  parameter MID_CAL_W = 12
) (
  input wire clock,
  input wire reset_n,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire irq,
  input wire slow_osc_run,
  input wire slow_clock_out,
  input wire ulp_osc_run,
  input wire [ULP_CAL_W-1:0] ulp_trim,
  input wire mid_osc_run,
  input wire [1:0] mid_band,
  input wire [MID_CAL_W-1:0] mid_trim,
  input wire mid_clock_out
);
  reg [3:0] age_r;
  wire [3:0] age_nxt;
  // Saturating age; flash load lands in the first cycles
  assign age_nxt = (age_r == 4'hf) ? age_r : age_r + 4'h1;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) age_r <= 4'h0;
    else age_r <= age_nxt;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_rd; $changed(readdata) |-> !waitrequest; endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  property p_ulp; age_r > 4'h4 && $past(ulp_osc_run) |-> ulp_osc_run; endproperty
  a_ulp: assert property (p_ulp) else $error("counter clock stopped");
  property p_ut; $changed(ulp_trim) && age_r == 4'hf |-> $past(write) || $past(write, 2) || $past(write, 3); endproperty
  a_ut: assert property (p_ut) else $error("ulp trim moved");
  property p_mb; $changed(mid_band) && age_r == 4'hf |-> $past(write) || $past(write, 2) || $past(write, 3); endproperty
  a_mb: assert property (p_mb) else $error("band moved");
  property p_mt; $changed(mid_trim) && age_r == 4'hf |-> $past(write) || $past(write, 2) || $past(write, 3); endproperty
  a_mt: assert property (p_mt) else $error("mid trim moved");
  property p_so; slow_clock_out |-> $past(slow_osc_run) || $past(slow_osc_run, 2) || $past(slow_osc_run, 3); endproperty
  a_so: assert property (p_so) else $error("slow out while off");
  property p_mo; mid_clock_out |-> $past(mid_osc_run) || $past(mid_osc_run, 2) || $past(mid_osc_run, 3); endproperty
  a_mo: assert property (p_mo) else $error("mid out while off");
  c_irq: cover property ($rose(irq));
  c_so: cover property ($rose(slow_clock_out));
  c_mo: cover property ($rose(mid_clock_out));
endmodule // ioc_osc_ctrl_chk
bind ioc_osc_ctrl ioc_osc_ctrl_chk #(.ULP_CAL_W(ULP_CAL_W), .MID_CAL_W(MID_CAL_W)) ioc_osc_ctrl_chk_inst (
  .clock(clock), .reset_n(reset_n), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .irq(irq), .slow_osc_run(slow_osc_run), .slow_clock_out(slow_clock_out), .ulp_osc_run(ulp_osc_run),
  .ulp_trim(ulp_trim), .mid_osc_run(mid_osc_run), .mid_band(mid_band), .mid_trim(mid_trim),
  .mid_clock_out(mid_clock_out));

// file: bench/internal_oscillator_control_tb.sv
// Purpose: Self-checking bench for the oscillator control block
// Assumes: Oscillator pins made from clock at slow rates
// Notes: Start-up counts are checked with a small slack for sync
`timescale 1ns/1ps
`include "ioc_defs.vh"
module internal_oscillator_control_tb;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  reg [5:0] address = 6'h00;
  reg read = 1'b0, write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [3:0] byteenable = 4'hf;
  reg standby = 1'b0, slow_request = 1'b0, mid_request = 1'b0;
  reg ulp_osc_clk = 1'b0, slow_osc_clk = 1'b0, mid_osc_clk = 1'b0;
  reg [4:0] f_ulp, rt;
  reg [11:0] f_mid;
  reg [1:0] f_band;
  reg [6:0] f_slow;
  reg [31:0] rd;
  reg prev;
  wire [31:0] readdata;
  wire waitrequest, irq, slow_osc_run, slow_clock_out, ulp_osc_run, mid_osc_run, mid_clock_out;
  wire [4:0] ulp_trim;
  wire [1:0] mid_band;
  wire [11:0] mid_trim;
  integer n_mismatch = 0, checks = 0, cyc = 0, i, k, e, t;
  ioc_osc_ctrl ioc_osc_ctrl_inst (.clock(clock), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .standby(standby), .slow_request(slow_request),
    .mid_request(mid_request), .ulp_osc_clk(ulp_osc_clk), .slow_osc_clk(slow_osc_clk),
    .mid_osc_clk(mid_osc_clk), .flash_ulp_trim(f_ulp), .flash_mid_trim(f_mid), .flash_mid_band(f_band),
    .flash_slow_trim(f_slow), .slow_osc_run(slow_osc_run), .slow_clock_out(slow_clock_out), .slow_trim(),
    .ulp_osc_run(ulp_osc_run), .ulp_trim(ulp_trim), .mid_osc_run(mid_osc_run), .mid_band(mid_band),
    .mid_trim(mid_trim), .mid_clock_out(mid_clock_out));
  always #25 clock = ~clock;
  // Oscillator pins well below a quarter of the clock
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ulp_osc_clk <= (cyc % 8) < 4;
    slow_osc_clk <= (cyc % 10) < 5;
    mid_osc_clk <= (cyc % 8) > 3;
  end
  // One Avalon cycle, held until waitrequest is seen low
  task bus(input w, input [5:0] a, input [31:0] d);
    begin
      t = 0;
      address <= a;
      writedata <= d;
      read <= !w;
      write <= w;
      @(posedge clock);
      while (waitrequest !== 1'b0 && t < 50) begin
        @(posedge clock);
        t = t + 1;
      end
      rd = readdata;
      if (t == 50) n_mismatch = n_mismatch + 1;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Hang guard, several times the expected run
  initial begin
    #3000000;
    n_mismatch = n_mismatch + 1;
    results;
  end
  initial begin
    e = $urandom(59052);
    {f_ulp, f_mid, f_band, f_slow} = {$urandom, $urandom};
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    bus(0, `IOC_OFS_MID_CTRL, 0);
    cmp(rd, {f_band, 2'b00, f_mid, 16'h0382});
    cmp(mid_trim[11:6], f_mid[11:6]);
    cmp(mid_trim[5:0], f_mid[5:0]);
    cmp(ulp_osc_run, 1);
    // Locked until the key is written
    bus(1, `IOC_OFS_ULP_CTRL, 0);
    bus(0, `IOC_OFS_ULP_CTRL, 0);
    cmp(rd, {27'h0, f_ulp});
    bus(1, `IOC_OFS_WPROT, `IOC_WPROT_KEY);
    bus(0, 6'h30, 0);
    cmp(rd, 0);
    // Band codes and divider ratios
    mid_request <= 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      bus(1, `IOC_OFS_MID_CTRL, {k[1:0], 2'b00, f_mid, 6'h00, k[1:0], 8'h82});
      repeat (20) @(posedge clock);
      cmp(mid_band, k);
      cmp(mid_osc_run, 1);
      bus(0, `IOC_OFS_MID_CTRL, 0);
      cmp(rd[`IOC_MID_EN_BIT], 1);
      e = 0;
      prev = 1'b1;
      repeat (640) begin
        @(posedge clock);
        e = e + (mid_clock_out & !prev);
        prev = mid_clock_out;
      end
      cmp(e >= (80 >> k) - 1 && e <= (80 >> k) + 1, 1);
    end
    mid_request <= 1'b0;
    repeat (8) @(posedge clock);
    cmp(mid_osc_run, 0);
    // Start-up length per code, seen through the interrupt
    bus(1, `IOC_OFS_IRQ_MASK, 1);
    for (k = 0; k < 8; k = k + 1) begin
      bus(1, `IOC_OFS_SLOW_CTRL, 0);
      bus(1, `IOC_OFS_STATUS, 3);
      @(posedge clock);
      cmp(irq, 0);
      bus(1, `IOC_OFS_SLOW_CTRL, {20'h0, 1'b0, k[2:0], 5'h00, k[0], 2'b10});
      e = (1 << k) + 2;
      t = 0;
      i = 0;
      while (irq !== 1'b1 && t < 2000) begin
        @(posedge clock);
        t = t + 1;
        i = i + (cyc % 8 == 0);
      end
      cmp(i >= e + 1 && i <= e + 5, 1);
      cmp(slow_osc_run, 1);
      t = 0;
      repeat (40) begin
        @(posedge clock);
        t = t + slow_clock_out;
      end
      cmp(t != 0, k[0]);
    end
    bus(1, `IOC_OFS_IRQ_MASK, 0);
    @(posedge clock);
    cmp(irq, 0);
    // Every mix of enable, gating, standby and request
    for (i = 0; i < 32; i = i + 1) begin
      standby <= i[0];
      slow_request <= i[1];
      bus(1, `IOC_OFS_SLOW_CTRL, {24'h0, i[3], i[4], 4'h0, i[2], 1'b0});
      repeat (6) @(posedge clock);
      cmp(slow_osc_run, i[2] & (i[3] ? i[1] : 1'b1) & (i[0] ? i[4] : 1'b1));
    end
    // Lock freezes the low-power register
    rt = $urandom;
    bus(1, `IOC_OFS_ULP_CTRL, {24'h0, 3'h4, rt});
    bus(1, `IOC_OFS_ULP_CTRL, 0);
    bus(0, `IOC_OFS_ULP_CTRL, 0);
    cmp(rd, {24'h0, 3'h4, rt});
    cmp(ulp_trim, rt);
    results;
  end
endmodule // internal_oscillator_control_tb
